// [common/ppa_pkg.sv]
// Constants and types for the position packet assembler
package ppa_pkg;
  typedef enum logic [3:0] {
    PPA_POLL = 4'h1,
    PPA_SOFT_RT = 4'h2,
    PPA_STREAM = 4'h4,
    PPA_RECORD = 4'h8
  } ppa_mode_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RUN = 3'h2,
    ST_PAD = 3'h4
  } ppa_state_e;
  localparam int NUM_AXES = 4;
  localparam int NUM_SLOTS = 6;
  localparam int AX_ELEMS = 8;
  localparam int AUX_ELEMS = 4;
  localparam int WORD_W = 34;
  localparam int FIFO_DEPTH = 4;
  // Region codes held in a layout slot
  localparam logic [2:0] RG_GLOBAL = 3'h0;
  localparam logic [2:0] RG_AX_FIRST = 3'h1;
  localparam logic [2:0] RG_AX_LAST = 3'h4;
  localparam logic [2:0] RG_AUX = 3'h5;
  localparam logic [2:0] SLOT_MAX = 3'h6;
  // Element lengths and byte offsets inside a region snapshot
  localparam logic [7:0] GLB_LEN = 8'h02;
  // Axis: status, position, timestamp, reference, coded ref, amplitude, add1, add2
  localparam logic [7:0][7:0] AX_LEN = {8'h04, 8'h04, 8'h04, 8'h06, 8'h0C, 8'h04, 8'h06, 8'h02};
  localparam logic [7:0][7:0] AX_OFF = {8'h26, 8'h22, 8'h1E, 8'h18, 8'h0C, 8'h08, 8'h02, 8'h00};
  // Auxiliary axis: status, position, timestamp, reference
  localparam logic [3:0][7:0] AUX_LEN = {8'h04, 8'h04, 8'h04, 8'h02};
  localparam logic [3:0][7:0] AUX_OFF = {8'h0A, 8'h06, 8'h02, 8'h00};
  localparam logic [7:0] WORD_ROUND = 8'h03;
  // Power-on layout: global region then axes 1 to 4
  localparam logic [5:0][2:0] DEF_SLOTS = {3'h0, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
  localparam logic [2:0] DEF_COUNT = 3'h5;
  localparam logic [7:0] DEF_AX_MASK = 8'h3F;
  localparam logic [3:0] DEF_AUX_MASK = 4'h0;
endpackage

// [common/ppa_stream_if.sv]
// Valid/ready word stream between assembler and buffer
`timescale 1ns/1ns
`default_nettype none
interface ppa_stream_if #(parameter int W = 34);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// [design/ppa_assembler.sv]
// Position packet assembler: captures per trigger, serialises layout into 32-bit words
// Behaviour
// - Fan-fault output follows the fan pin live, never latched, never in packets.
// - Fan-fault output stays zero when fan supervision is not supported.
// - Host configures over TCP; soft real-time data leaves as UDP packets.
// - Four modes exist; polling is active after reset.
// - Outside polling, each trigger emits only elements selected in the layout.
// - Every packet starts with the global information region.
// - Axis regions appear in strictly ascending order; descending layouts are invalid.
// - The auxiliary axis region, when present, is the last region.
// - Packet length is padded up to a multiple of four bytes.
// - Global region carries a two-byte trigger event count.
// - Axis status 2, position 6, timestamp 4, reference 12 bytes.
// - Axis coded reference 6 bytes; amplitude 4 bytes, A low, B high.
// - Each additional datum is 4 bytes: status low pair, value high pair.
// - Auxiliary axis: status 2, position 4, timestamp 4, reference 4 bytes.
// - Reset layout is global plus four axes with the default elements.
// - Polling captures only on host command; answer marked for the TCP path.
// - In polling, external and internal triggers are ignored.
// - Latched error bits stay set and repeat until the host clears them.
`timescale 1ns/1ns
`default_nettype none
module ppa_assembler (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Pins from outside
  input wire logic trig_ext_pin,
  input wire logic trig_int_pin,
  input wire logic fan_fail_pin,
  input wire logic fan_sup_pin,
  // Host commands
  input wire logic sw_trig,
  input wire logic mode_wr,
  input wire logic [3:0] mode_sel,
  input wire logic cfg_wr,
  input wire logic [5:0][2:0] cfg_slots,
  input wire logic [2:0] cfg_count,
  input wire logic [3:0][7:0] cfg_ax_mask,
  input wire logic [3:0] cfg_aux_mask,
  input wire logic [3:0][15:0] err_set,
  input wire logic [3:0] err_clr,
  // Axis data
  input wire logic [3:0][15:0] ax_status,
  input wire logic [3:0][47:0] ax_pos,
  input wire logic [3:0][31:0] ax_time,
  input wire logic [3:0][47:0] ax_ref1,
  input wire logic [3:0][47:0] ax_ref2,
  input wire logic [3:0][47:0] ax_coded,
  input wire logic [3:0][31:0] ax_amp,
  input wire logic [3:0][31:0] ax_add1,
  input wire logic [3:0][31:0] ax_add2,
  input wire logic [15:0] aux_status,
  input wire logic [31:0] aux_pos,
  input wire logic [31:0] aux_time,
  input wire logic [31:0] aux_ref,
  // Packet word stream
  input wire logic out_ready,
  output logic out_valid,
  output logic [31:0] out_data,
  output logic out_last,
  output logic out_tcp,
  // Status
  output logic fan_fault,
  output logic [3:0] mode,
  output logic busy,
  output logic cfg_reject,
  output logic trig_drop
);
  function automatic logic cfg_is_valid(input logic [5:0][2:0] s, input logic [2:0] n);
    logic ok;
    logic [2:0] prev;
    ok = (n != 3'h0) && (n <= ppa_pkg::SLOT_MAX) && (s[0] == ppa_pkg::RG_GLOBAL);
    prev = ppa_pkg::RG_GLOBAL;
    for (int i = 1; i < ppa_pkg::NUM_SLOTS; i++) begin
      if (3'(i) < n) begin
        if (s[i] == ppa_pkg::RG_AUX) begin
          ok = ok && (3'(i) == n - 3'h1);
        end else if (s[i] >= ppa_pkg::RG_AX_FIRST && s[i] <= ppa_pkg::RG_AX_LAST
                     && s[i] > prev) begin
          prev = s[i];
        end else begin
          ok = 1'b0;
        end
      end
    end
    return ok;
  endfunction

  function automatic logic [5:0] pkt_words(input logic [5:0][2:0] s, input logic [2:0] n,
                                           input logic [3:0][7:0] axm, input logic [3:0] am);
    logic [7:0] len;
    len = '0;
    for (int i = 0; i < ppa_pkg::NUM_SLOTS; i++) begin
      if (3'(i) < n) begin
        if (s[i] == ppa_pkg::RG_GLOBAL) begin
          len = len + ppa_pkg::GLB_LEN;
        end else if (s[i] == ppa_pkg::RG_AUX) begin
          for (int e = 0; e < ppa_pkg::AUX_ELEMS; e++) begin
            if (am[e]) len = len + ppa_pkg::AUX_LEN[e];
          end
        end else begin
          for (int e = 0; e < ppa_pkg::AX_ELEMS; e++) begin
            if (axm[2'(s[i] - 3'h1)][e]) len = len + ppa_pkg::AX_LEN[e];
          end
        end
      end
    end
    len = len + ppa_pkg::WORD_ROUND;
    return len[7:2];
  endfunction

  // Pin synchronisers: 0 ext trigger, 1 int trigger, 2 fan fail, 3 fan supported
  logic [3:0] s1_r, s2_r;
  logic [1:0] trig_prev_r;
  logic trig_any, trig_acc;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      trig_prev_r <= '0;
    end else begin
      s1_r <= {fan_sup_pin, fan_fail_pin, trig_int_pin, trig_ext_pin};
      s2_r <= s1_r;
      trig_prev_r <= s2_r[1:0];
    end
  end

  // Mode, layout and status group
  ppa_pkg::ppa_mode_e mode_r, mode_nxt;
  ppa_pkg::ppa_state_e st_r, st_nxt;
  logic [5:0][2:0] slots_r, slots_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [3:0][7:0] axm_r, axm_nxt;
  logic [3:0] am_r, am_nxt;
  logic fan_r, fan_nxt, rej_r, rej_nxt, drop_r, drop_nxt, cfg_take;

  always_comb begin
    trig_any = sw_trig;
    if (mode_r != ppa_pkg::PPA_POLL) begin
      trig_any = sw_trig || (s2_r[0] && !trig_prev_r[0]) || (s2_r[1] && !trig_prev_r[1]);
    end
    trig_acc = trig_any && (st_r == ppa_pkg::ST_IDLE);
    cfg_take = cfg_wr && cfg_is_valid(cfg_slots, cfg_count) && (st_r == ppa_pkg::ST_IDLE)
               && !trig_acc;
    mode_nxt = mode_r;
    if (mode_wr && $onehot(mode_sel)) begin
      mode_nxt = ppa_pkg::ppa_mode_e'(mode_sel);
    end
    slots_nxt = cfg_take ? cfg_slots : slots_r;
    cnt_nxt = cfg_take ? cfg_count : cnt_r;
    axm_nxt = cfg_take ? cfg_ax_mask : axm_r;
    am_nxt = cfg_take ? cfg_aux_mask : am_r;
    rej_nxt = cfg_wr && !cfg_take;
    drop_nxt = trig_any && !trig_acc;
    fan_nxt = s2_r[2] && s2_r[3];
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= ppa_pkg::PPA_POLL;
      slots_r <= ppa_pkg::DEF_SLOTS;
      cnt_r <= ppa_pkg::DEF_COUNT;
      axm_r <= {ppa_pkg::NUM_AXES{ppa_pkg::DEF_AX_MASK}};
      am_r <= ppa_pkg::DEF_AUX_MASK;
      rej_r <= 1'b0;
      drop_r <= 1'b0;
      fan_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      slots_r <= slots_nxt;
      cnt_r <= cnt_nxt;
      axm_r <= axm_nxt;
      am_r <= am_nxt;
      rej_r <= rej_nxt;
      drop_r <= drop_nxt;
      fan_r <= fan_nxt;
    end
  end

  // Error latches, trigger count and data snapshot group
  logic [3:0][15:0] err_r, err_nxt;
  logic [15:0] tcount_r, tcount_nxt;
  logic [3:0][335:0] ax_snap_r, ax_snap_nxt;
  logic [111:0] aux_snap_r, aux_snap_nxt;

  always_comb begin
    tcount_nxt = trig_acc ? tcount_r + 16'h0001 : tcount_r;
    ax_snap_nxt = ax_snap_r;
    aux_snap_nxt = aux_snap_r;
    for (int i = 0; i < ppa_pkg::NUM_AXES; i++) begin
      err_nxt[i] = (err_r[i] & ~{16{err_clr[i]}}) | err_set[i];
      if (trig_acc) begin
        ax_snap_nxt[i] = {ax_add2[i], ax_add1[i], ax_amp[i], ax_coded[i], ax_ref2[i],
                          ax_ref1[i], ax_time[i], ax_pos[i],
                          ax_status[i] | err_r[i] | err_set[i]};
      end
    end
    if (trig_acc) begin
      aux_snap_nxt = {aux_ref, aux_time, aux_pos, aux_status};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      err_r <= '0;
      tcount_r <= '0;
      ax_snap_r <= '0;
      aux_snap_r <= '0;
    end else begin
      err_r <= err_nxt;
      tcount_r <= tcount_nxt;
      ax_snap_r <= ax_snap_nxt;
      aux_snap_r <= aux_snap_nxt;
    end
  end

  // Serialiser group: one byte per cycle, four bytes per pushed word
  ppa_stream_if #(.W(ppa_pkg::WORD_W)) fifo_in ();
  ppa_stream_if #(.W(ppa_pkg::WORD_W)) fifo_out ();
  logic [2:0] slot_r, slot_nxt, elem_r, elem_nxt, region, elem_last;
  logic [3:0] byte_r, byte_nxt;
  logic [1:0] nb_r, nb_nxt;
  logic [5:0] wcnt_r, wcnt_nxt, words;
  logic [31:0] acc_r, acc_nxt, word;
  logic tcp_r, tcp_nxt, push, adv, esel, wlast;
  logic [7:0] elen, off, cur_byte;

  always_comb begin
    region = slots_r[slot_r];
    words = pkt_words(slots_r, cnt_r, axm_r, am_r);
    esel = 1'b1;
    elen = ppa_pkg::GLB_LEN;
    elem_last = 3'h0;
    off = {4'h0, byte_r};
    cur_byte = tcount_r[{byte_r[0], 3'b000} +: 8];
    if (region == ppa_pkg::RG_AUX) begin
      esel = am_r[elem_r[1:0]];
      elen = ppa_pkg::AUX_LEN[elem_r[1:0]];
      elem_last = 3'(ppa_pkg::AUX_ELEMS - 1);
      off = ppa_pkg::AUX_OFF[elem_r[1:0]] + {4'h0, byte_r};
      cur_byte = aux_snap_r[{off[3:0], 3'b000} +: 8];
    end else if (region != ppa_pkg::RG_GLOBAL) begin
      esel = axm_r[2'(region - 3'h1)][elem_r];
      elen = ppa_pkg::AX_LEN[elem_r];
      elem_last = 3'(ppa_pkg::AX_ELEMS - 1);
      off = ppa_pkg::AX_OFF[elem_r] + {4'h0, byte_r};
      cur_byte = ax_snap_r[2'(region - 3'h1)][{off[5:0], 3'b000} +: 8];
    end
    st_nxt = st_r;
    slot_nxt = slot_r;
    elem_nxt = elem_r;
    byte_nxt = byte_r;
    acc_nxt = acc_r;
    nb_nxt = nb_r;
    wcnt_nxt = wcnt_r;
    tcp_nxt = tcp_r;
    push = 1'b0;
    adv = 1'b0;
    word = acc_r;
    unique case (st_r)
      ppa_pkg::ST_IDLE: begin
        if (trig_acc) begin
          st_nxt = ppa_pkg::ST_RUN;
          slot_nxt = '0;
          elem_nxt = '0;
          byte_nxt = '0;
          acc_nxt = '0;
          nb_nxt = '0;
          wcnt_nxt = '0;
          tcp_nxt = (mode_r == ppa_pkg::PPA_POLL);
        end
      end
      ppa_pkg::ST_RUN: begin
        if (!esel) begin
          adv = 1'b1;
        end else begin
          word[{nb_r, 3'b000} +: 8] = cur_byte;
          push = (nb_r == 2'h3);
          if (!push || fifo_in.ready) begin
            acc_nxt = push ? '0 : word;
            nb_nxt = nb_r + 2'h1;
            wcnt_nxt = wcnt_r + {5'h00, push};
            if (byte_r == elen[3:0] - 4'h1) begin
              byte_nxt = '0;
              adv = 1'b1;
            end else begin
              byte_nxt = byte_r + 4'h1;
            end
          end
        end
        if (adv) begin
          if (elem_r == elem_last) begin
            elem_nxt = '0;
            if (slot_r == cnt_r - 3'h1) begin
              st_nxt = (nb_nxt != 2'h0) ? ppa_pkg::ST_PAD : ppa_pkg::ST_IDLE;
            end else begin
              slot_nxt = slot_r + 3'h1;
            end
          end else begin
            elem_nxt = elem_r + 3'h1;
          end
        end
      end
      ppa_pkg::ST_PAD: begin
        push = 1'b1;
        if (fifo_in.ready) begin
          st_nxt = ppa_pkg::ST_IDLE;
          acc_nxt = '0;
          nb_nxt = '0;
          wcnt_nxt = wcnt_r + 6'h01;
        end
      end
      default: st_nxt = ppa_pkg::ST_IDLE;
    endcase
    wlast = (wcnt_r == words - 6'h01);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ppa_pkg::ST_IDLE;
      slot_r <= '0;
      elem_r <= '0;
      byte_r <= '0;
      acc_r <= '0;
      nb_r <= '0;
      wcnt_r <= '0;
      tcp_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      slot_r <= slot_nxt;
      elem_r <= elem_nxt;
      byte_r <= byte_nxt;
      acc_r <= acc_nxt;
      nb_r <= nb_nxt;
      wcnt_r <= wcnt_nxt;
      tcp_r <= tcp_nxt;
    end
  end

  assign fifo_in.valid = push;
  assign fifo_in.data = {tcp_r, wlast, word};

  ppa_fifo #(.WIDTH(ppa_pkg::WORD_W), .DEPTH(ppa_pkg::FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .wr(fifo_in),
    .rd(fifo_out)
  );

  // Output register group
  logic ov_r, ov_nxt;
  logic [ppa_pkg::WORD_W-1:0] od_r, od_nxt;

  always_comb begin
    fifo_out.ready = !ov_r || out_ready;
    ov_nxt = ov_r && !out_ready;
    od_nxt = od_r;
    if (fifo_out.valid && fifo_out.ready) begin
      ov_nxt = 1'b1;
      od_nxt = fifo_out.data;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ov_r <= 1'b0;
      od_r <= '0;
    end else begin
      ov_r <= ov_nxt;
      od_r <= od_nxt;
    end
  end

  assign out_valid = ov_r;
  assign out_data = od_r[31:0];
  assign out_last = od_r[32];
  assign out_tcp = od_r[33];
  assign fan_fault = fan_r;
  assign mode = mode_r;
  assign busy = !st_r[0];
  assign cfg_reject = rej_r;
  assign trig_drop = drop_r;

  logic seen_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seen_r <= 1'b0;
    end else begin
      seen_r <= seen_r || mode_wr;
    end
  end

  fan_follow_a: assert property (@(posedge clock) disable iff (!rst_n)
    s2_r[2] && s2_r[3] |=> fan_fault) else $error("fan fault not shown");
  fan_unlatched_a: assert property (@(posedge clock) disable iff (!rst_n)
    !(s2_r[2] && s2_r[3]) |=> !fan_fault) else $error("fan fault held");
  poll_default_a: assert property (@(posedge clock) disable iff (!rst_n)
    !seen_r |-> mode == ppa_pkg::PPA_POLL) else $error("mode not polling after reset");
  poll_swonly_a: assert property (@(posedge clock) disable iff (!rst_n)
    mode_r == ppa_pkg::PPA_POLL && st_r == ppa_pkg::ST_IDLE && !sw_trig |=> !busy)
    else $error("hw trigger in polling");
  layout_valid_a: assert property (@(posedge clock) disable iff (!rst_n)
    cfg_is_valid(slots_r, cnt_r)) else $error("active layout invalid");
  cfg_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
    cfg_wr && !cfg_is_valid(cfg_slots, cfg_count) |=> cfg_reject && $stable(slots_r))
    else $error("bad layout applied");
  pkt_end_a: assert property (@(posedge clock) disable iff (!rst_n)
    trig_acc |-> ##[1:400] (push && fifo_in.ready && wlast)) else $error("packet not closed");
  pad_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
    st_r == ppa_pkg::ST_PAD |-> nb_r != 2'h0 && (word >> {nb_r, 3'b000}) == 32'h0000_0000)
    else $error("pad bytes not zero");
  err_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    !err_clr[0] |=> (err_r[0] & $past(err_r[0])) == $past(err_r[0])) else $error("error bit lost");
  poll_pkt_c: cover property (@(posedge clock) disable iff (!rst_n)
    push && wlast && tcp_r);
  stream_pkt_c: cover property (@(posedge clock) disable iff (!rst_n)
    push && wlast && !tcp_r && mode_r == ppa_pkg::PPA_STREAM);
  pad_c: cover property (@(posedge clock) disable iff (!rst_n) st_r == ppa_pkg::ST_PAD);
  reject_c: cover property (@(posedge clock) disable iff (!rst_n) cfg_reject);
endmodule
`default_nettype wire

// [design/ppa_fifo.sv]
// Word FIFO in flip-flops with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module ppa_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Fill and drain sides
  ppa_stream_if.snk wr,
  ppa_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign wr.ready = cnt_r != (AW+1)'(DEPTH);
  assign rd.valid = cnt_r != '0;
  assign rd.data = mem_r[rp_r];
  assign push = wr.valid && wr.ready;
  assign pop = rd.valid && rd.ready;

  always_comb begin
    mem_nxt = mem_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wp_r] = wr.data;
      wp_nxt = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + AW'(1);
    end
    if (pop) begin
      rp_nxt = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + AW'(1);
    end
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      mem_r <= mem_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  fifo_bound_a: assert property (@(posedge clock) disable iff (!rst_n)
    cnt_r <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
  fifo_count_a: assert property (@(posedge clock) disable iff (!rst_n)
    push && !pop |=> cnt_r == $past(cnt_r) + (AW+1)'(1)) else $error("fifo push lost");
  fifo_full_c: cover property (@(posedge clock) disable iff (!rst_n) !wr.ready);
endmodule
`default_nettype wire

// [verif/ppa_assembler_tb.sv]
// Self-checking bench for the position packet assembler
`timescale 1ns/1ns
`default_nettype none
module ppa_assembler_tb;
  logic clock, rst_n, trig_ext_pin, trig_int_pin, fan_fail_pin, fan_sup_pin, sw_trig;
  logic mode_wr, cfg_wr, out_ready, out_valid, out_last, out_tcp, fan_fault, busy;
  logic cfg_reject, trig_drop, stall_en, got, got_last, got_tcp, exp_tcp;
  logic [3:0] mode_sel, cfg_aux_mask, err_clr, mode, am;
  logic [5:0][2:0] cfg_slots, sl;
  logic [2:0] cfg_count, cn;
  logic [3:0][7:0] cfg_ax_mask, axm;
  logic [3:0][15:0] err_set, ax_status, lat;
  logic [3:0][47:0] ax_pos, ax_ref1, ax_ref2, ax_coded;
  logic [3:0][31:0] ax_time, ax_amp, ax_add1, ax_add2;
  logic [15:0] aux_status, cnt;
  logic [31:0] aux_pos, aux_time, aux_ref, out_data, got_data, seed;
  logic [7:0] q[$];
  int n_errors, compares;

  ppa_assembler dut (
    .clock, .rst_n, .trig_ext_pin, .trig_int_pin, .fan_fail_pin, .fan_sup_pin, .sw_trig,
    .mode_wr, .mode_sel, .cfg_wr, .cfg_slots, .cfg_count, .cfg_ax_mask, .cfg_aux_mask,
    .err_set, .err_clr, .ax_status, .ax_pos, .ax_time, .ax_ref1, .ax_ref2, .ax_coded,
    .ax_amp, .ax_add1, .ax_add2, .aux_status, .aux_pos, .aux_time, .aux_ref, .out_ready,
    .out_valid, .out_data, .out_last, .out_tcp, .fan_fault, .mode, .busy, .cfg_reject,
    .trig_drop
  );
  ppa_host_model host (
    .clock, .rst_n, .out_valid, .out_data, .out_last, .out_tcp, .out_ready, .stall_en,
    .got, .got_data, .got_last, .got_tcp
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  function automatic logic [31:0] rnd();
    seed = (seed >> 1) ^ (seed[0] ? 32'h8020_0003 : 32'h0000_0000);
    return seed;
  endfunction

  function automatic void put(input logic [95:0] v, input int n);
    for (int i = 0; i < n; i++) q.push_back(v[8*i +: 8]);
  endfunction

  // Expected packet bytes for the active layout, lowest byte first
  function automatic void build();
    logic [2:0] c;
    int a;
    q.delete();
    for (int s = 0; s < cn; s++) begin
      c = sl[s];
      a = c - 1;
      if (c == 3'h0) put(cnt, 2);
      else if (c == 3'h5) begin
        if (am[0]) put(aux_status, 2);
        if (am[1]) put(aux_pos, 4);
        if (am[2]) put(aux_time, 4);
        if (am[3]) put(aux_ref, 4);
      end else begin
        if (axm[a][0]) put(ax_status[a] | lat[a], 2);
        if (axm[a][1]) put(ax_pos[a], 6);
        if (axm[a][2]) put(ax_time[a], 4);
        if (axm[a][3]) put({ax_ref2[a], ax_ref1[a]}, 12);
        if (axm[a][4]) put(ax_coded[a], 6);
        if (axm[a][5]) put(ax_amp[a], 4);
        if (axm[a][6]) put(ax_add1[a], 4);
        if (axm[a][7]) put(ax_add2[a], 4);
      end
    end
    while (q.size() % 4 != 0) q.push_back(8'h00);
  endfunction

  always @(posedge clock) begin
    if (got === 1'b1) begin
      logic [31:0] w;
      w = 32'h0000_0000;
      check(q.size() != 0, 1'b1);
      for (int i = 0; i < 4; i++) if (q.size() > 0) w[8*i +: 8] = q.pop_front();
      check(got_data, w);
      check(got_last, q.size() == 0);
      check(got_tcp, exp_tcp);
    end
  end

  // One packet: fresh axis data, a trigger from src, optional second trigger while busy
  task automatic run(input int src, input logic tcp, input bit dup);
    @(posedge clock);
    stall_en <= seed[0];
    for (int a = 0; a < 4; a++) begin
      ax_status[a] <= 16'(rnd());
      ax_pos[a] <= 48'({rnd(), rnd()});
      ax_time[a] <= rnd();
      ax_ref1[a] <= 48'({rnd(), rnd()});
      ax_ref2[a] <= 48'({rnd(), rnd()});
      ax_coded[a] <= 48'({rnd(), rnd()});
      ax_amp[a] <= rnd();
      ax_add1[a] <= rnd();
      ax_add2[a] <= rnd();
    end
    {aux_status, aux_pos, aux_time, aux_ref} <= {16'(rnd()), rnd(), rnd(), rnd()};
    @(posedge clock);
    if (src == 0) sw_trig <= 1'b1;
    else if (src == 1) trig_ext_pin <= 1'b1;
    else trig_int_pin <= 1'b1;
    @(posedge clock);
    sw_trig <= 1'b0;
    cnt = cnt + 16'h0001;
    exp_tcp = tcp;
    build();
    cyc(4);
    trig_ext_pin <= 1'b0;
    trig_int_pin <= 1'b0;
    if (dup) begin
      sw_trig <= 1'b1;
      @(posedge clock);
      sw_trig <= 1'b0;
      #1 check(trig_drop, 1'b1);
    end
    for (int i = 0; i < 3000 && (q.size() != 0 || busy !== 1'b0); i++) @(posedge clock);
    check(q.size(), 0);
  endtask

  task automatic cfg(input logic [5:0][2:0] s, input logic [2:0] c,
                     input logic [3:0][7:0] m, input logic [3:0] x, input logic bad);
    @(posedge clock);
    cfg_slots <= s;
    cfg_count <= c;
    cfg_ax_mask <= m;
    cfg_aux_mask <= x;
    cfg_wr <= 1'b1;
    @(posedge clock);
    cfg_wr <= 1'b0;
    #1 check(cfg_reject, bad);
    if (!bad) begin
      sl = s;
      cn = c;
      axm = m;
      am = x;
    end
  endtask

  task automatic set_mode(input logic [3:0] m, input logic [3:0] exp);
    @(posedge clock);
    mode_sel <= m;
    mode_wr <= 1'b1;
    @(posedge clock);
    mode_wr <= 1'b0;
    #1 check(mode, exp);
  endtask

  initial begin
    seed = 32'he051_c331;
    n_errors = 0;
    compares = 0;
    cnt = 16'h0000;
    lat = '0;
    exp_tcp = 1'b1;
    sl = {3'h0, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
    cn = 3'h5;
    axm = {4{8'h3F}};
    am = 4'h0;
    {rst_n, trig_ext_pin, trig_int_pin, fan_fail_pin, fan_sup_pin, sw_trig, mode_wr} = '0;
    {cfg_wr, stall_en} = '0;
    {mode_sel, cfg_slots, cfg_count, cfg_ax_mask, cfg_aux_mask, err_set, err_clr} = '0;
    {ax_status, ax_pos, ax_time, ax_ref1, ax_ref2, ax_coded, ax_amp, ax_add1, ax_add2} = '0;
    {aux_status, aux_pos, aux_time, aux_ref} = '0;
    cyc(5);
    rst_n <= 1'b1;
    @(posedge clock);
    #1 check(mode, 4'h1);
    check({out_valid, busy, fan_fault, cfg_reject, trig_drop}, 5'h00);
    run(0, 1'b1, 1'b1);
    @(posedge clock);
    trig_ext_pin <= 1'b1;
    trig_int_pin <= 1'b1;
    cyc(6);
    trig_ext_pin <= 1'b0;
    trig_int_pin <= 1'b0;
    #1 check(busy, 1'b0);
    set_mode(4'h3, 4'h1);
    for (int i = 1; i < 4; i++) begin
      set_mode(4'h1 << i, 4'h1 << i);
      run(i - 1, 1'b0, 1'b0);
    end
    set_mode(4'h2, 4'h2);
    for (int i = 0; i < 4; i++) begin
      cfg({3'h0, 3'h0, 3'h5, 3'h3, 3'h1, 3'h0}, 3'h4, rnd(), 4'(rnd()), 1'b0);
      run(0, 1'b0, 1'b0);
    end
    cfg({3'h0, 3'h0, 3'h0, 3'h3, 3'h4, 3'h0}, 3'h3, rnd(), 4'hF, 1'b1);
    cfg({3'h0, 3'h0, 3'h0, 3'h1, 3'h5, 3'h0}, 3'h3, rnd(), 4'hF, 1'b1);
    cfg({3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h1}, 3'h2, rnd(), 4'hF, 1'b1);
    run(0, 1'b0, 1'b0);
    @(posedge clock);
    fan_sup_pin <= 1'b1;
    fan_fail_pin <= 1'b1;
    cyc(4);
    #1 check(fan_fault, 1'b1);
    run(0, 1'b0, 1'b0);
    fan_fail_pin <= 1'b0;
    cyc(4);
    #1 check(fan_fault, 1'b0);
    @(posedge clock);
    fan_fail_pin <= 1'b1;
    fan_sup_pin <= 1'b0;
    cyc(6);
    #1 check(fan_fault, 1'b0);
    cfg({3'h0, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0}, 3'h5, {4{8'h3F}}, 4'h0, 1'b0);
    @(posedge clock);
    err_set[0] <= 16'h0010;
    err_set[2] <= 16'h8001;
    lat[0] = 16'h0010;
    lat[2] = 16'h8001;
    @(posedge clock);
    err_set <= '0;
    repeat (2) run(0, 1'b0, 1'b0);
    err_clr <= 4'h5;
    lat = '0;
    @(posedge clock);
    err_clr <= 4'h0;
    run(0, 1'b0, 1'b0);
    set_mode(4'h1, 4'h1);
    run(0, 1'b1, 1'b0);
    summarize();
  end

  initial begin
    cyc(40000);
    n_errors++;
    summarize();
  end
endmodule
`default_nettype wire

// [verif/ppa_host_model.sv]
// Host side sink model that accepts packet words, with optional stalls
`timescale 1ns/1ns
`default_nettype none
module ppa_host_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Word stream from the assembler
  input wire logic out_valid,
  input wire logic [31:0] out_data,
  input wire logic out_last,
  input wire logic out_tcp,
  output logic out_ready,
  // Stall control and received words
  input wire logic stall_en,
  output logic got,
  output logic [31:0] got_data,
  output logic got_last,
  output logic got_tcp
);
  logic [2:0] cnt_r;
  // A stalling host takes one word in eight cycles, so the buffer fills
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 3'h0;
      out_ready <= 1'b0;
      got <= 1'b0;
      got_data <= 32'h0000_0000;
      got_last <= 1'b0;
      got_tcp <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 3'h1;
      out_ready <= !stall_en || cnt_r == 3'h0;
      got <= out_valid && out_ready;
      got_data <= out_data;
      got_last <= out_last;
      got_tcp <= out_tcp;
    end
  end
endmodule
`default_nettype wire
